// [srs_pkg.sv]
// Shared constants and types for the E1 receive signaling and link select
package srs_pkg;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [11:0] OFF_SELECT     = 12'h000;
  localparam logic [11:0] OFF_FLAGS0     = 12'h004;
  localparam logic [11:0] OFF_FLAGS1     = 12'h008;
  localparam logic [11:0] OFF_IRQ_STAT   = 12'h00C;
  localparam logic [11:0] OFF_IRQ_MASK   = 12'h010;
  localparam logic [4:0]  STORE_PAGE     = 5'h01;  // 0x080..0x0FC
  localparam int          STORE_PAGE_LSB = 7;
  localparam int          WORD_LSB       = 2;

  // Reset values
  localparam logic [7:0]  SELECT_RST = 8'h00;
  localparam logic [15:0] FLAGS_RST  = 16'h0000;
  localparam logic [1:0]  IRQ_RST    = 2'h0;
  localparam logic [3:0]  NIBBLE_RST = 4'hF;

  // Select register layout
  localparam int CODE_LSB  = 0;
  localparam int CODE_W    = 3;
  localparam int EN_LSB    = 3;
  localparam int EN_W      = 5;

  // Select codes
  localparam logic [2:0] CODE_PLAIN    = 3'h0;
  localparam logic [2:0] CODE_CAS      = 3'h1;
  localparam logic [2:0] CODE_ONES     = 3'h2;
  localparam logic [2:0] CODE_CAS_ONES = 3'h3;
  localparam logic [2:0] CODE_DE_SIG   = 3'h4;

  // Frame positions
  localparam logic [4:0] TS_ALIGN     = 5'h00;
  localparam logic [4:0] TS_SIG       = 5'h10;
  localparam logic [2:0] NATBIT_FIRST = 3'h3;
  localparam logic [2:0] BIT_LAST     = 3'h7;
  localparam logic [2:0] SIG_FIRST    = 3'h4;
  localparam logic [3:0] MF_ALIGN     = 4'h0;
  localparam logic [3:0] CH_FLAG_TOP  = 4'hF;

  // Interrupt status bits
  localparam int IRQ_FLAGS0 = 1;
  localparam int IRQ_FLAGS1 = 0;

  localparam int HTRANS_ACTIVE = 1;

  // One received line bit with its frame position
  typedef struct packed {
    logic       bit_val;
    logic       valid;
    logic [4:0] ts;
    logic [2:0] bitpos;
    logic       nonfas;
    logic [3:0] mf;
    logic       cas_active;
  } srs_line_s;

  typedef enum logic [1:0] {BUS_IDLE, BUS_RD_FETCH, BUS_RD_DONE} srs_bus_e;

endpackage

// [srs_rx_sig_link.sv]
// E1 receive signaling routing, data link select and CAS change flags
//
// Summary of operation
// [R01] Natbit8 enable set: non-FAS timeslot 0 bit 7 feeds the data link.
// [R02] Natbit7 enable set: bit 6 feeds the data link, else excluded.
// [R03] Natbit6 enable set: bit 5 feeds the data link, else excluded.
// [R04] Natbit5 enable set: bit 4 feeds the data link, else excluded.
// [R05] Natbit4 enable set: bit 3 feeds the data link; enables reset 0.
// [R06] Enables act only for select codes 000, 001 and 100.
// [R07] Select field resets 000; 000/100 pass timeslot 16 serially; 101-111 unused.
// [R08] Codes 001/011: ts16 to serial, storage, overhead, signaling every slot.
// [R09] Code 010: link all ones; ts16 to serial, storage, overhead, signaling.
// [R10] CAS only for 001/011; 011 forces ones; 000-011 route D/E out.
// [R11] First change register: bit 7 timeslot 0 down to bit 0 timeslot 7.
// [R12] Second change register: bit 7 timeslot 8 down to bit 0 timeslot 15.
// [R13] Flag shows change since last read; reading clears; reset to 0.
// [R14] Timeslot 0 change flag never becomes active.
// [R15] Change registers work only with CAS in the stream, else no changes.
// [R16] New signaling nibble compared with stored one; mismatch sets flag.
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module srs_rx_sig_link (
  input  wire logic              CLK_I,
  input  wire logic              RSTN_I,
  input  wire logic              HSEL_I,
  input  wire logic [31:0]       HADDR_I,
  input  wire logic [1:0]        HTRANS_I,
  input  wire logic              HWRITE_I,
  input  wire logic [2:0]        HSIZE_I,
  input  wire logic [31:0]       HWDATA_I,
  input  wire logic              HREADY_I,
  output logic      [31:0]       HRDATA_O,
  output logic                   HREADYOUT_O,
  output logic                   HRESP_O,
  input  wire srs_pkg::srs_line_s LINE_I,
  output logic                   SER_O,
  output logic                   SER_VALID_O,
  output logic                   FRTD_O,
  output logic                   FRTD_VALID_O,
  output logic                   DLINK_O,
  output logic                   DLINK_VALID_O,
  output logic                   OH_O,
  output logic                   OH_VALID_O,
  output logic                   SIG_O,
  output logic                   SIG_VALID_O,
  output logic                   IRQ_O
);

  logic [7:0]              select_ff;
  logic [15:0]             flags_ff;
  logic [1:0]              irq_stat_ff;
  logic [1:0]              irq_mask_ff;
  logic [3:0]              sig_mem [32];
  logic [6:0]              shift_ff;
  srs_pkg::srs_bus_e       bus_ff;
  logic [11:0]             rd_addr_ff;
  logic [11:0]             wr_addr_ff;
  logic                    wr_pend_ff;
  logic [31:0]             hrdata_ff;
  logic                    ser_ff;
  logic                    ser_v_ff;
  logic                    frtd_ff;
  logic                    frtd_v_ff;
  logic                    dl_ff;
  logic                    dl_v_ff;
  logic                    oh_ff;
  logic                    oh_v_ff;
  logic                    sig_ff;
  logic                    sig_v_ff;

  logic [2:0]              code;
  logic [4:0]              nat_en;
  logic                    dl_mode;
  logic                    ones_mode;
  logic                    cas_mode;
  logic                    store_mode;
  logic                    unused_code;
  logic                    cas_on;
  logic                    cas_rd;
  logic                    cas_seen_ff;
  logic                    ts16;
  logic                    nat_slot;
  logic [2:0]              nat_idx;
  logic                    nat_en_bit;
  logic [7:0]              ts16_byte;
  logic                    byte_done;
  logic [4:0]              ch_hi;
  logic [4:0]              ch_lo;
  logic [15:0]             chg_set;
  logic [15:0]             flag_clr;
  logic                    acc;
  logic                    wr_commit;
  logic [31:0]             rd_value;
  logic [1:0]              irq_set;
  logic [1:0]              irq_clr;
  logic [3:0]              cur_nibble;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  // Select field decode
  assign code        = select_ff[srs_pkg::CODE_LSB +: srs_pkg::CODE_W];
  assign nat_en      = select_ff[srs_pkg::EN_LSB +: srs_pkg::EN_W];
  assign dl_mode     = (code == srs_pkg::CODE_PLAIN) ||
                       (code == srs_pkg::CODE_CAS) ||
                       (code == srs_pkg::CODE_DE_SIG);          // [R06]
  assign ones_mode   = (code == srs_pkg::CODE_ONES) ||
                       (code == srs_pkg::CODE_CAS_ONES);        // [R09] [R10]
  assign cas_mode    = (code == srs_pkg::CODE_CAS) ||
                       (code == srs_pkg::CODE_CAS_ONES);        // [R10]
  assign store_mode  = cas_mode || (code == srs_pkg::CODE_ONES);
  assign unused_code = code > srs_pkg::CODE_DE_SIG;             // [R07]
  assign cas_on      = cas_mode && LINE_I.cas_active;           // [R15]
  assign cas_rd      = cas_mode && cas_seen_ff;                 // [R15]

  // Line position decode
  assign ts16      = LINE_I.valid && (LINE_I.ts == srs_pkg::TS_SIG);
  assign nat_slot  = LINE_I.valid && LINE_I.nonfas &&
                     (LINE_I.ts == srs_pkg::TS_ALIGN) &&
                     (LINE_I.bitpos >= srs_pkg::NATBIT_FIRST);
  assign nat_idx   = LINE_I.bitpos - srs_pkg::NATBIT_FIRST;
  assign nat_en_bit = nat_en[nat_idx]; // [R01] [R02] [R03] [R04] [R05]
  assign ts16_byte = {shift_ff, LINE_I.bit_val};
  assign byte_done = ts16 && (LINE_I.bitpos == srs_pkg::BIT_LAST) &&
                     (LINE_I.mf != srs_pkg::MF_ALIGN);
  assign ch_hi     = {1'b0, LINE_I.mf};
  assign ch_lo     = {1'b1, LINE_I.mf};
  assign cur_nibble = sig_mem[LINE_I.ts];

  // Stream CAS state kept between bits; line fields only count when valid
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cas_seen_ff <= 1'b0;
    end else if (LINE_I.valid) begin
      cas_seen_ff <= LINE_I.cas_active; // [R15]
    end
  end

  // Serial output passes every bit; ts16 blanked for unused codes
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ser_ff   <= 1'b1;
      ser_v_ff <= 1'b0;
    end else begin
      ser_v_ff <= LINE_I.valid;
      ser_ff   <= (ts16 && unused_code) ? 1'b1 : LINE_I.bit_val; // [R07]
    end
  end

  // D/E channel to frame timing output for codes 000 to 011
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      frtd_ff   <= 1'b1;
      frtd_v_ff <= 1'b0;
    end else begin
      frtd_v_ff <= ts16 && (code <= srs_pkg::CODE_CAS_ONES); // [R10]
      frtd_ff   <= LINE_I.bit_val;
    end
  end

  // National bit data link, enabled per bit or forced to ones
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      dl_ff   <= 1'b1;
      dl_v_ff <= 1'b0;
    end else begin
      dl_v_ff <= nat_slot && ((dl_mode && nat_en_bit) || ones_mode); // [R06]
      dl_ff   <= ones_mode ? 1'b1 : LINE_I.bit_val;                   // [R09]
    end
  end

  // Overhead output carries ts16 for storing codes only
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      oh_ff   <= 1'b1;
      oh_v_ff <= 1'b0;
    end else begin
      oh_v_ff <= ts16 && store_mode; // [R08] [R09]
      oh_ff   <= LINE_I.bit_val;
    end
  end

  // Signaling output: stored nibble every slot under CAS, raw ts16 for codes 010 and 100, else none
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sig_ff   <= 1'b1;
      sig_v_ff <= 1'b0;
    end else if (cas_mode) begin
      sig_v_ff <= LINE_I.valid && (LINE_I.bitpos >= srs_pkg::SIG_FIRST); // [R08]
      sig_ff   <= cur_nibble[~LINE_I.bitpos[1:0]];
    end else begin
      sig_v_ff <= ts16 && ((code == srs_pkg::CODE_ONES) ||
                           (code == srs_pkg::CODE_DE_SIG)); // [R09]
      sig_ff   <= LINE_I.bit_val;
    end
  end

  // Timeslot 16 byte assembly, first bit is the most significant
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      shift_ff <= 7'h00;
    end else if (ts16) begin
      shift_ff <= ts16_byte[6:0];
    end
  end

  // Signaling storage, two channel nibbles per multiframe frame
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int i = 0; i < 32; i++) begin
        sig_mem[i] <= srs_pkg::NIBBLE_RST;
      end
    end else if (byte_done && store_mode) begin
      sig_mem[ch_hi] <= ts16_byte[7:4]; // [R08]
      sig_mem[ch_lo] <= ts16_byte[3:0];
    end
  end

  // Change detection against stored nibble; timeslot 0 bit masked
  always_comb begin
    chg_set = 16'h0000;
    if (byte_done && cas_on && (ts16_byte[7:4] != sig_mem[ch_hi])) begin
      chg_set[srs_pkg::CH_FLAG_TOP - LINE_I.mf] = 1'b1; // [R16] [R11] [R12]
    end
    chg_set[srs_pkg::CH_FLAG_TOP] = 1'b0;               // [R14]
  end

  // Clear on read of each change register
  always_comb begin
    flag_clr = 16'h0000;
    if (bus_ff == srs_pkg::BUS_RD_FETCH) begin
      if (rd_addr_ff == srs_pkg::OFF_FLAGS0) begin
        flag_clr[15:8] = 8'hFF;
      end
      if (rd_addr_ff == srs_pkg::OFF_FLAGS1) begin
        flag_clr[7:0] = 8'hFF;
      end
    end
  end

  // Sticky change flags, a new change wins over the read clear
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      flags_ff <= srs_pkg::FLAGS_RST;                    // [R13]
    end else begin
      flags_ff <= (flags_ff & ~flag_clr) | chg_set;      // [R13]
    end
  end

  // Bus acceptance and write commit
  assign acc       = HSEL_I && HTRANS_I[srs_pkg::HTRANS_ACTIVE] && HREADY_I;
  assign wr_commit = wr_pend_ff && HREADY_I;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
    end else if (HREADY_I) begin
      wr_pend_ff <= acc && HWRITE_I;
      wr_addr_ff <= HADDR_I[11:0];
    end
  end

  // Read sequencing: one wait cycle while the read data is fetched
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      bus_ff     <= srs_pkg::BUS_IDLE;
      rd_addr_ff <= 12'h000;
    end else begin
      case (bus_ff)
        srs_pkg::BUS_IDLE, srs_pkg::BUS_RD_DONE: begin
          if (acc && !HWRITE_I) begin
            bus_ff     <= srs_pkg::BUS_RD_FETCH;
            rd_addr_ff <= HADDR_I[11:0];
          end else begin
            bus_ff <= srs_pkg::BUS_IDLE;
          end
        end
        srs_pkg::BUS_RD_FETCH: begin
          bus_ff <= srs_pkg::BUS_RD_DONE;
        end
        default: begin
          bus_ff <= srs_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Read multiplexer; change registers read zero without CAS
  always_comb begin
    rd_value = 32'h0000_0000;
    if (rd_addr_ff[11:srs_pkg::STORE_PAGE_LSB] == srs_pkg::STORE_PAGE) begin
      rd_value[3:0] = sig_mem[rd_addr_ff[6:srs_pkg::WORD_LSB]];
    end else begin
      case (rd_addr_ff)
        srs_pkg::OFF_SELECT:   rd_value[7:0] = select_ff;
        srs_pkg::OFF_FLAGS0:   rd_value[7:0] = cas_rd ? flags_ff[15:8] : 8'h00;
        srs_pkg::OFF_FLAGS1:   rd_value[7:0] = cas_rd ? flags_ff[7:0] : 8'h00;
        srs_pkg::OFF_IRQ_STAT: rd_value[1:0] = irq_stat_ff;
        srs_pkg::OFF_IRQ_MASK: rd_value[1:0] = irq_mask_ff;
        default:               rd_value = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (bus_ff == srs_pkg::BUS_RD_FETCH) begin
      hrdata_ff <= rd_value;
    end
  end

  // Select register write
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      select_ff <= srs_pkg::SELECT_RST; // [R05] [R07]
    end else if (wr_commit && (wr_addr_ff == srs_pkg::OFF_SELECT)) begin
      select_ff <= HWDATA_I[7:0];
    end
  end

  // Interrupt status (write one to clear, set wins) and mask
  assign irq_set[srs_pkg::IRQ_FLAGS0] = |chg_set[15:8];
  assign irq_set[srs_pkg::IRQ_FLAGS1] = |chg_set[7:0];
  assign irq_clr = (wr_commit && (wr_addr_ff == srs_pkg::OFF_IRQ_STAT)) ?
                   HWDATA_I[1:0] : 2'h0;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      irq_stat_ff <= srs_pkg::IRQ_RST;
      irq_mask_ff <= srs_pkg::IRQ_RST;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
      if (wr_commit && (wr_addr_ff == srs_pkg::OFF_IRQ_MASK)) begin
        irq_mask_ff <= HWDATA_I[1:0];
      end
    end
  end

  // Output drive
  assign HRDATA_O      = hrdata_ff;
  assign HREADYOUT_O   = (bus_ff != srs_pkg::BUS_RD_FETCH);
  assign HRESP_O       = 1'b0;
  assign IRQ_O         = |(irq_stat_ff & irq_mask_ff);
  assign SER_O         = ser_ff;
  assign SER_VALID_O   = ser_v_ff;
  assign FRTD_O        = frtd_ff;
  assign FRTD_VALID_O  = frtd_v_ff;
  assign DLINK_O       = dl_ff;
  assign DLINK_VALID_O = dl_v_ff;
  assign OH_O          = oh_ff;
  assign OH_VALID_O    = oh_v_ff;
  assign SIG_O         = sig_ff;
  assign SIG_VALID_O   = sig_v_ff;

  // Checks on routing, flags and bus timing
  chk_dl_natbit8: assert property ( // [R01]
    (nat_slot && LINE_I.bitpos == srs_pkg::BIT_LAST && dl_mode && nat_en[4])
    |=> (DLINK_VALID_O && DLINK_O == $past(LINE_I.bit_val)))
    else $error("Natbit8 not passed to data link");
  chk_dl_disabled: assert property ( // [R02] [R03] [R04] [R05]
    (nat_slot && dl_mode && !nat_en_bit) |=> !DLINK_VALID_O)
    else $error("Disabled national bit reached data link");
  chk_dl_forced: assert property ( // [R09] [R10]
    (nat_slot && ones_mode) |=> (DLINK_VALID_O && DLINK_O))
    else $error("Data link not forced to ones");
  chk_dl_unused: assert property ( // [R06] [R07]
    (LINE_I.valid && unused_code) |=> (!DLINK_VALID_O && !OH_VALID_O))
    else $error("Unused code produced link output");
  chk_oh_ts16: assert property ( // [R08]
    OH_VALID_O |-> $past(ts16 && store_mode))
    else $error("Overhead output outside timeslot 16");
  chk_sig_every: assert property ( // [R08]
    (cas_mode && LINE_I.valid && LINE_I.bitpos >= srs_pkg::SIG_FIRST)
    |=> SIG_VALID_O)
    else $error("Signaling output missing in CAS mode");
  chk_flag_ts0: assert property ( // [R14]
    flags_ff[srs_pkg::CH_FLAG_TOP] == 1'b0)
    else $error("Timeslot 0 change flag set");
  chk_flag_set: assert property ( // [R16] [R11] [R12]
    (chg_set != 16'h0000) |=> ((flags_ff & $past(chg_set)) == $past(chg_set)))
    else $error("Change flag not set on mismatch");
  chk_read_clear: assert property ( // [R13]
    (flag_clr[15:8] == 8'hFF && chg_set[15:8] == 8'h00)
    |=> flags_ff[15:8] == 8'h00)
    else $error("Change register not cleared by read");
  chk_cas_off: assert property ( // [R15]
    !cas_on |-> chg_set == 16'h0000)
    else $error("Change flagged without CAS");
  chk_rd_wait: assert property (
    (acc && !HWRITE_I) |=> !HREADYOUT_O ##1 HREADYOUT_O)
    else $error("Read wait timing wrong");

  cov_cas_change: cover property (chg_set != 16'h0000);
  cov_read_flags: cover property (flag_clr[15:8] == 8'hFF && flags_ff != 0);
  cov_forced_ones: cover property (nat_slot && ones_mode);
  cov_irq: cover property (IRQ_O);

endmodule

// [srs_rx_sig_link_note_end.sv]
// Intentionally left without logic

// [srs_line_model.sv]
// Line-side model that feeds framed E1 bits to the receiver
`timescale 1ns/1ps
module srs_line_model (
  input  wire logic          clk_i,
  output srs_pkg::srs_line_s line_o
);
  srs_pkg::srs_line_s cur;
  logic               tog;

  // Start idle with no valid bit
  initial begin
    cur = '0;
    tog = 1'h0;
  end

  // Idle data line toggles so a stale bit is never seen
  always @(posedge clk_i) begin
    tog <= ~tog;
  end

  // Present the current bit, or the toggling level while idle
  always_comb begin
    line_o = cur;
    if (!cur.valid) begin
      line_o.bit_val = tog;
    end
  end

  // Drive one valid bit from the next rising edge
  task automatic send(input logic [4:0] t, input logic [2:0] p,
                      input logic nf, input logic [3:0] m,
                      input logic c, input logic b);
    @(posedge clk_i);
    cur <= '{bit_val: b, valid: 1'h1, ts: t, bitpos: p, nonfas: nf,
             mf: m, cas_active: c};
  endtask

  // End the burst at the next rising edge
  task automatic stop();
    @(posedge clk_i);
    cur.valid <= 1'h0;
  endtask

  // Send one timeslot 16 byte back to back, first bit is the MSB
  task automatic byte16(input logic [3:0] m, input logic c,
                        input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      send(5'h10, i[2:0], 1'h0, m, c, v[7-i]);
    end
    stop();
  endtask
endmodule

// [srs_rx_sig_link_tb.sv]
// Self-checking bench for the E1 receive signaling and link select block
`timescale 1ns/1ps
module srs_rx_sig_link_tb;
  typedef struct packed {
    logic [7:0] sel;
    logic [4:0] ts;
    logic [2:0] pos;
    logic       nf;
    logic       b;
    logic [7:0] e;
  } srs_row_s;

  localparam int NROW  = 27;
  localparam int LIMIT = 20000;

  logic               clk;
  logic               rst_n;
  logic               hsel;
  logic [31:0]        haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [2:0]         hsize;
  logic [31:0]        hwdata;
  logic [31:0]        hrdata;
  logic               hready;
  logic               hresp;
  srs_pkg::srs_line_s line;
  logic               ser, ser_v, frtd, frtd_v, dl, dl_v;
  logic               oh, oh_v, sig, sig_v, irq;
  logic [7:0]         vec;
  int                 miscompares;
  int                 check_count;
  int                 cycles = 0;
  logic [11:0]        ra [5] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
  // Select, timeslot, bit, non-FAS, bit value, expected output vector
  srs_row_s rows [NROW] = '{
    '{8'h80, 5'h00, 3'h7, 1'h1, 1'h0, 8'h50}, '{8'h80, 5'h00, 3'h7, 1'h1, 1'h1, 8'hD8},
    '{8'h00, 5'h00, 3'h7, 1'h1, 1'h1, 8'hC0}, '{8'h80, 5'h00, 3'h7, 1'h0, 1'h1, 8'hC0},
    '{8'h40, 5'h00, 3'h6, 1'h1, 1'h1, 8'hD8}, '{8'h80, 5'h00, 3'h6, 1'h1, 1'h1, 8'hC0},
    '{8'h20, 5'h00, 3'h5, 1'h1, 1'h0, 8'h50}, '{8'h10, 5'h00, 3'h4, 1'h1, 1'h1, 8'hD8},
    '{8'h08, 5'h00, 3'h3, 1'h1, 1'h1, 8'hD8}, '{8'hF0, 5'h00, 3'h3, 1'h1, 1'h1, 8'hC0},
    '{8'h09, 5'h00, 3'h3, 1'h1, 1'h0, 8'h50}, '{8'h0C, 5'h00, 3'h3, 1'h1, 1'h0, 8'h50},
    '{8'h02, 5'h00, 3'h3, 1'h1, 1'h0, 8'h58}, '{8'h03, 5'h00, 3'h3, 1'h1, 1'h0, 8'h58},
    '{8'hFA, 5'h00, 3'h7, 1'h1, 1'h0, 8'h58}, '{8'h0D, 5'h00, 3'h3, 1'h1, 1'h1, 8'hC0},
    '{8'h05, 5'h10, 3'h2, 1'h0, 1'h0, 8'hC0}, '{8'h07, 5'h10, 3'h2, 1'h0, 1'h0, 8'hC0},
    '{8'h00, 5'h10, 3'h2, 1'h0, 1'h0, 8'h60}, '{8'h04, 5'h10, 3'h2, 1'h0, 1'h1, 8'hC3},
    '{8'h01, 5'h10, 3'h2, 1'h0, 1'h1, 8'hE4}, '{8'h03, 5'h10, 3'h1, 1'h0, 1'h1, 8'hE4},
    '{8'h01, 5'h05, 3'h4, 1'h0, 1'h0, 8'h43}, '{8'h03, 5'h09, 3'h6, 1'h0, 1'h0, 8'h43},
    '{8'h02, 5'h10, 3'h5, 1'h0, 1'h0, 8'h66}, '{8'h02, 5'h05, 3'h5, 1'h0, 1'h0, 8'h40},
    '{8'h00, 5'h05, 3'h5, 1'h0, 1'h1, 8'hC0}};

  // Line outputs packed for one comparison; link and signaling data only count when valid, serial data is raw
  assign vec = {ser, ser_v, frtd_v, dl_v, dl_v & dl, oh_v, sig_v, sig_v & sig};

  srs_rx_sig_link u_srs_rx_sig_link (
    .CLK_I(clk), .RSTN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .LINE_I(line),
    .SER_O(ser), .SER_VALID_O(ser_v), .FRTD_O(frtd),
    .FRTD_VALID_O(frtd_v), .DLINK_O(dl), .DLINK_VALID_O(dl_v),
    .OH_O(oh), .OH_VALID_O(oh_v), .SIG_O(sig), .SIG_VALID_O(sig_v),
    .IRQ_O(irq)
  );

  srs_line_model u_srs_line_model (.clk_i(clk), .line_o(line));

  // Comparisons of register words and of line output vectors
  task automatic chk_reg(input string n, input logic [31:0] e,
                         input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_out(input string n, input logic [7:0] e,
                         input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  // Sample ready and data mid-cycle, so the sampling edge never races
  task automatic wait_rdy(output logic [31:0] rd);
    logic r;
    do begin
      @(negedge clk);
      r  = hready;
      rd = hrdata;
      @(posedge clk);
    end while (r !== 1'h1);
  endtask

  // One AHB-Lite single word transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'h1;
    haddr  <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy(rd);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] x;
    ahb(1'h1, a, v, x);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
                        input string n);
    logic [31:0] x;
    ahb(1'h0, a, 32'h0, x);
    chk_reg(n, e, x);
  endtask

  task automatic irq_chk(input logic e);
    @(negedge clk);
    chk_reg("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // Verdict and end of run
  task automatic final_report();
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // 20 MHz clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // Cut a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      final_report();
    end
  end

  // Main sequence
  initial begin
    rst_n = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    miscompares = 0;
    check_count = 0;
    repeat (15) @(posedge clk);
    @(negedge clk);
    chk_out("reset_line", 8'h80, vec);
    chk_reg("reset_bus", 32'h1, {29'h0, hresp, irq, hready});
    @(posedge clk);
    rst_n <= 1'h1;
    foreach (ra[i]) rd_chk(ra[i], 32'h0, "reset_reg");
    wr(12'h000, 32'hFFFFFFFF);
    rd_chk(12'h000, 32'h000000FF, "select");
    rd_chk(12'h040, 32'h0, "unmapped");
    // Routing table, one isolated bit per row
    foreach (rows[i]) begin
      wr(12'h000, {24'h0, rows[i].sel});
      u_srs_line_model.send(rows[i].ts, rows[i].pos, rows[i].nf, 4'h0,
                            1'h0, rows[i].b);
      u_srs_line_model.stop();
      @(negedge clk);
      chk_out("line_row", rows[i].e, vec);
      chk_out("line_data", {6'h0, rows[i].e[5] & rows[i].b,
              rows[i].e[2] & rows[i].b}, {6'h0, frtd_v & frtd, oh_v & oh});
    end
    // Signaling change on timeslot 3, unmasked
    wr(12'h010, 32'h3);
    wr(12'h000, 32'h1);
    u_srs_line_model.byte16(4'h3, 1'h1, 8'hA5);
    rd_chk(12'h004, 32'h10, "flags0");
    irq_chk(1'h1);
    rd_chk(12'h004, 32'h0, "flags0_again");
    rd_chk(12'h08C, 32'hA, "store3");
    rd_chk(12'h0CC, 32'h5, "store19");
    wr(12'h08C, 32'h0);
    rd_chk(12'h08C, 32'hA, "store3_ro");
    rd_chk(12'h00C, 32'h2, "irq_stat");
    wr(12'h00C, 32'h2);
    irq_chk(1'h0);
    // Change on timeslot 10 while masked
    wr(12'h010, 32'h0);
    u_srs_line_model.byte16(4'hA, 1'h1, 8'h35);
    rd_chk(12'h00C, 32'h1, "irq_stat1");
    irq_chk(1'h0);
    wr(12'h010, 32'h1);
    irq_chk(1'h1);
    rd_chk(12'h008, 32'h20, "flags1");
    wr(12'h00C, 32'h1);
    irq_chk(1'h0);
    u_srs_line_model.byte16(4'hA, 1'h1, 8'h35);
    rd_chk(12'h008, 32'h0, "flags1_same");
    // No flags without signaling in the stream or with a plain code
    u_srs_line_model.byte16(4'h4, 1'h0, 8'h75);
    rd_chk(12'h004, 32'h0, "flags0_nocas");
    wr(12'h000, 32'h0);
    u_srs_line_model.byte16(4'h5, 1'h1, 8'h75);
    rd_chk(12'h004, 32'h0, "flags0_code0");
    // Last timeslot of the second register, code with forced ones
    wr(12'h000, 32'h3);
    u_srs_line_model.byte16(4'hF, 1'h1, 8'h15);
    rd_chk(12'h008, 32'h1, "flags1_ts15");
    // Second reset in mid-run
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    rd_chk(12'h000, 32'h0, "select_rst");
    final_report();
  end
endmodule
